// [hw/fmev_top.sv]
/*
 Holds the margin level and D-flash section erase verify sequencer with
 its AXI4-Lite register slave.
 Assumes a D-flash read port on the same clock that answers each
 request with one rd_valid pulse, and a software master on the bus.
*/
// Implementation choices: the AXI4-Lite register port and the address map.
// What this block does
// (R1) Code 0x0d word 0 block, word 1 level
// (R2) User margin launch records level, sets complete
// (R3) User margin accepts settings 0, 1, 2
// (R4) Margin commands need index 001 at launch
// (R5) Margin commands reject unsupported settings
// (R6) Margin commands reject invalid block select
// (R7) Commands unavailable in current mode raise error
// (R8) Code 0x0e field margin, special modes only
// (R9) Field margin launch records level, sets complete
// (R10) Field margin also accepts settings 3, 4
// (R11) Software applies field levels only in factory
// (R12) Code 0x10 block, start address, word count
// (R13) Reads section, checks erased, then completes
// (R14) Erase verify needs index 010 at launch
// (R15) Erase verify rejects invalid global address
// (R16) Erase verify rejects odd start address
// (R17) Erase verify rejects section past block end
// (R18) Any read error sets verify error flag
// (R19) Uncorrectable read error sets uncorrectable flag
// (R20) Never protection error; margins leave verify clear
// (R21) Per-block margin kept until changed or reset
`include "fmev_regs.svh"

module fmev_top #(
    parameter logic [16:0] DF_BYTES = `FMEV_DF_BYTES
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Register bus
    input wire fmev_pkg::fmev_axi_req_t axi_req_i,
    output fmev_pkg::fmev_axi_rsp_t axi_rsp_o,
    // D-flash read port
    output fmev_pkg::fmev_rd_req_t rd_req_o,
    input wire fmev_pkg::fmev_rd_rsp_t rd_rsp_i,
    // Status
    output logic command_complete_flag_o
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic aw_got;
        logic [5:0] aw_word;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic command_complete_flag;
        logic access_error_flag;
        logic protection_violation_flag;
        logic mg1;
        logic mg0;
        logic [2:0] idx;
        logic [2:0][15:0] words;
        logic special;
        logic [2:0] msel;
        logic [fmev_pkg::NBLK-1:0][2:0] margin;
        fmev_pkg::fmev_state_t state;
        logic [15:0] addr;
        logic [15:0] left;
        logic rd_req;
        logic [2:0] rd_margin;
    } fmev_st_t;

    fmev_st_t st_reg;
    fmev_st_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Block select is P-flash range or the D-flash block
    function automatic logic fmev_blk_ok(input logic [6:0] blk);
        fmev_blk_ok = (blk == `FMEV_DF_BLK) || (blk >= `FMEV_PF_BLK_LO);
    endfunction : fmev_blk_ok

    // Margin slot: 0 for D-flash, 1.. for P-flash blocks
    function automatic logic [2:0] fmev_slot(input logic [6:0] blk);
        logic [6:0] ofs;
        ofs = blk - `FMEV_PF_BLK_LO;
        if (blk == `FMEV_DF_BLK) begin
            fmev_slot = 3'h0;
        end else begin
            fmev_slot = ofs[2:0] + 3'h1;
        end
    endfunction : fmev_slot

    // Read view of the register at a word offset
    function automatic logic [31:0] fmev_rd_view(input fmev_st_t s, input logic [5:0] ofs);
        fmev_rd_view = 32'h0;
        case (ofs)
            `FMEV_OFS_FLASH_STATUS: begin
                fmev_rd_view[`FMEV_BIT_COMMAND_COMPLETE_FLAG] = s.command_complete_flag;
                fmev_rd_view[`FMEV_BIT_ACCESS_ERROR_FLAG] = s.access_error_flag;
                fmev_rd_view[`FMEV_BIT_PROTECTION_VIOLATION_FLAG] = s.protection_violation_flag;
                fmev_rd_view[`FMEV_BIT_MG1] = s.mg1;
                fmev_rd_view[`FMEV_BIT_MG0] = s.mg0;
            end
            `FMEV_OFS_WORD_INDEX: begin
                fmev_rd_view[2:0] = s.idx;
            end
            `FMEV_OFS_CMD_WORD: begin
                if (s.idx <= `FMEV_IDX_2) begin
                    fmev_rd_view[15:0] = s.words[s.idx[1:0]];
                end
            end
            `FMEV_OFS_MODE: begin
                fmev_rd_view[0] = s.special;
            end
            `FMEV_OFS_MARGIN_SEL: begin
                fmev_rd_view[2:0] = s.msel;
            end
            `FMEV_OFS_MARGIN_RD: begin
                if (32'(s.msel) < fmev_pkg::NBLK) begin
                    fmev_rd_view[2:0] = s.margin[s.msel];
                end
            end
            default: begin
                fmev_rd_view = 32'h0;
            end
        endcase
    endfunction : fmev_rd_view

    // Offsets past the last register answer with an error
    function automatic logic fmev_mapped(input logic [5:0] ofs);
        fmev_mapped = (ofs <= `FMEV_OFS_MARGIN_RD);
    endfunction : fmev_mapped

    ////////////////////////////////////////////////////////////////////////
    // Next state

    // Fields of the loaded command words
    logic [7:0] cmd;
    logic [6:0] blk;
    // Start plus twice the count can need 18 bits
    logic [17:0] sec_end;
    logic bad;
    logic do_wr;

    always_comb begin
        st_next = st_reg;
        st_next.rd_req = 1'b0;
        cmd = st_reg.words[0][15:8];
        blk = st_reg.words[0][6:0];
        sec_end = {2'b00, st_reg.words[1]} + {1'b0, st_reg.words[2], 1'b0};
        bad = 1'b0;
        do_wr = 1'b0;

        // Write address and data, taken in either order
        if (axi_req_i.awvalid && st_reg.awready) begin
            st_next.aw_got = 1'b1;
            st_next.aw_word = axi_req_i.awaddr[7:2];
        end
        if (axi_req_i.wvalid && st_reg.wready) begin
            st_next.w_got = 1'b1;
            st_next.w_data = axi_req_i.wdata;
            st_next.w_strb = axi_req_i.wstrb;
        end
        if (st_reg.bvalid && axi_req_i.bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            do_wr = 1'b1;
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = fmev_mapped(st_reg.aw_word) ? `FMEV_RESP_OKAY : `FMEV_RESP_SLVERR;
        end
        st_next.awready = !st_next.aw_got && !st_next.bvalid;
        st_next.wready = !st_next.w_got && !st_next.bvalid;

        // Read channel
        if (st_reg.rvalid && axi_req_i.rready) begin
            st_next.rvalid = 1'b0;
        end
        if (axi_req_i.arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = fmev_rd_view(st_reg, axi_req_i.araddr[7:2]);
            st_next.rresp = fmev_mapped(axi_req_i.araddr[7:2]) ?
                `FMEV_RESP_OKAY : `FMEV_RESP_SLVERR;
        end
        st_next.arready = !st_next.rvalid;

        // Register writes; command registers are frozen while busy
        if (do_wr && st_reg.w_strb[0]) begin
            case (st_reg.aw_word)
                // Error flags clear on one; the complete flag launches
                `FMEV_OFS_FLASH_STATUS: begin
                    if (st_reg.w_data[`FMEV_BIT_ACCESS_ERROR_FLAG]) begin
                        st_next.access_error_flag = 1'b0;
                    end
                    if (st_reg.w_data[`FMEV_BIT_PROTECTION_VIOLATION_FLAG]) begin
                        st_next.protection_violation_flag = 1'b0;
                    end
                    if (st_reg.w_data[`FMEV_BIT_COMMAND_COMPLETE_FLAG] && st_reg.command_complete_flag &&
                        !st_reg.access_error_flag && !st_reg.protection_violation_flag) begin
                        st_next.command_complete_flag = 1'b0;
                        st_next.mg1 = 1'b0;
                        st_next.mg0 = 1'b0;
                        st_next.state = fmev_pkg::ST_CHECK;
                    end
                end

                // Index picks the word the next access sees
                `FMEV_OFS_WORD_INDEX: begin
                    if (st_reg.command_complete_flag) begin
                        st_next.idx = st_reg.w_data[2:0];
                    end
                end

                // Low byte on strobe 0, high byte on strobes 0 and 1 together
                `FMEV_OFS_CMD_WORD: begin
                    if (st_reg.command_complete_flag && st_reg.idx <= `FMEV_IDX_2) begin
                        st_next.words[st_reg.idx[1:0]][7:0] = st_reg.w_data[7:0];
                        if (st_reg.w_strb[1]) begin
                            st_next.words[st_reg.idx[1:0]][15:8] = st_reg.w_data[15:8];
                        end
                    end
                end

                // Mode and margin select stay writable while busy
                `FMEV_OFS_MODE: begin
                    st_next.special = st_reg.w_data[0];
                end
                `FMEV_OFS_MARGIN_SEL: begin
                    st_next.msel = st_reg.w_data[2:0];
                end
                default: begin
                end
            endcase
        end

        // Command sequencer; its flag sets follow the clears above
        case (st_reg.state)
            fmev_pkg::ST_IDLE: begin
            end

            // Parameter check one cycle after launch
            fmev_pkg::ST_CHECK: begin
                st_next.state = fmev_pkg::ST_DONE;
                case (cmd)
                    `FMEV_CMD_USER_MARGIN: begin // R1
                        bad = (st_reg.idx != `FMEV_IDX_1) // R4
                            || (st_reg.words[1] > `FMEV_USER_MAX) // R3 R5
                            || !fmev_blk_ok(blk); // R6
                        if (!bad) begin
                            st_next.margin[fmev_slot(blk)] = st_reg.words[1][2:0]; // R2 R21
                        end
                    end

                    // Special mode only, two more settings
                    `FMEV_CMD_FIELD_MARGIN: begin // R8
                        bad = !st_reg.special // R7
                            || (st_reg.idx != `FMEV_IDX_1) // R4
                            || (st_reg.words[1] > `FMEV_FIELD_MAX) // R10 R5
                            || !fmev_blk_ok(blk); // R6
                        if (!bad) begin
                            st_next.margin[fmev_slot(blk)] = st_reg.words[1][2:0]; // R9 R21
                        end
                    end

                    // Section must lie inside the D-flash block
                    `FMEV_CMD_ERASE_VERIFY: begin // R12
                        bad = (st_reg.idx != `FMEV_IDX_2) // R14
                            || (blk != `FMEV_DF_BLK) // R15
                            || ({1'b0, st_reg.words[1]} >= DF_BYTES) // R15
                            || st_reg.words[1][0] // R16
                            || (sec_end > {1'b0, DF_BYTES}); // R17
                        if (!bad) begin
                            st_next.addr = st_reg.words[1];
                            st_next.left = st_reg.words[2];
                            if (st_reg.words[2] != 16'h0) begin
                                st_next.state = fmev_pkg::ST_READ; // R13
                            end
                        end
                    end

                    // Unknown codes are refused
                    default: begin
                        bad = 1'b1;
                    end
                endcase
                if (bad) begin
                    st_next.access_error_flag = 1'b1; // R7
                end
            end

            // One word per request at the D-flash margin
            fmev_pkg::ST_READ: begin
                st_next.rd_req = 1'b1; // R13
                st_next.rd_margin = st_reg.margin[0]; // R21
                st_next.state = fmev_pkg::ST_WAIT;
            end

            // A fault sets both verify flags
            fmev_pkg::ST_WAIT: begin
                if (rd_rsp_i.rd_valid) begin
                    if (rd_rsp_i.rd_fault) begin
                        st_next.mg1 = 1'b1; // R18
                        st_next.mg0 = 1'b1; // R19
                    end else if (rd_rsp_i.rd_data != `FMEV_ERASED) begin
                        st_next.mg1 = 1'b1; // R18
                    end
                    st_next.addr = st_reg.addr + 16'h2;
                    st_next.left = st_reg.left - 16'h1;
                    if (st_reg.left == 16'h1) begin
                        st_next.state = fmev_pkg::ST_DONE;
                    end else begin
                        st_next.state = fmev_pkg::ST_READ;
                    end
                end
            end

            // Completion one cycle after the last step
            fmev_pkg::ST_DONE: begin
                st_next.command_complete_flag = 1'b1; // R2 R9 R13
                st_next.state = fmev_pkg::ST_IDLE;
            end
            default: begin
                st_next.state = fmev_pkg::ST_IDLE;
            end
        endcase

        // Protection flag is never set here; only the write-one clear above changes it
        st_next.protection_violation_flag = st_next.protection_violation_flag & st_reg.protection_violation_flag; // R20
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    // Complete flag comes up set: idle after reset
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= '0;
            st_reg.command_complete_flag <= 1'b1;
            st_reg.state <= fmev_pkg::ST_IDLE;
            st_reg.margin <= {fmev_pkg::NBLK{`FMEV_MARGIN_NORMAL}}; // R21
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Bus answers
    assign axi_rsp_o.awready = st_reg.awready;
    assign axi_rsp_o.wready = st_reg.wready;
    assign axi_rsp_o.bresp = st_reg.bresp;
    assign axi_rsp_o.bvalid = st_reg.bvalid;
    assign axi_rsp_o.arready = st_reg.arready;
    assign axi_rsp_o.rdata = st_reg.rdata;
    assign axi_rsp_o.rresp = st_reg.rresp;
    assign axi_rsp_o.rvalid = st_reg.rvalid;

    // Read port to the D-flash array
    assign rd_req_o.rd_req = st_reg.rd_req;
    assign rd_req_o.rd_addr = {`FMEV_DF_BLK, st_reg.addr};
    assign rd_req_o.rd_margin = st_reg.rd_margin;

    // High while idle or complete
    assign command_complete_flag_o = st_reg.command_complete_flag;

endmodule : fmev_top

// [hw/fmev_regs.svh]
/*
 Holds the register offsets, field positions, command codes and limits
 of the margin and section erase verify sequencer.
 Assumes it is included by its bare name after the package.
*/
`ifndef FMEV_REGS_SVH
`define FMEV_REGS_SVH

// Register word offsets (byte address bits 7:2)
`define FMEV_OFS_FLASH_STATUS 6'h00
`define FMEV_OFS_WORD_INDEX 6'h01
`define FMEV_OFS_CMD_WORD 6'h02
`define FMEV_OFS_MODE 6'h03
`define FMEV_OFS_MARGIN_SEL 6'h04
`define FMEV_OFS_MARGIN_RD 6'h05

// Status field positions
`define FMEV_BIT_COMMAND_COMPLETE_FLAG 7
`define FMEV_BIT_ACCESS_ERROR_FLAG 5
`define FMEV_BIT_PROTECTION_VIOLATION_FLAG 4
`define FMEV_BIT_MG1 1
`define FMEV_BIT_MG0 0

// Command codes and word indices
`define FMEV_CMD_USER_MARGIN 8'h0d
`define FMEV_CMD_FIELD_MARGIN 8'h0e
`define FMEV_CMD_ERASE_VERIFY 8'h10
`define FMEV_IDX_0 3'h0
`define FMEV_IDX_1 3'h1
`define FMEV_IDX_2 3'h2

// Margin limits and array layout
`define FMEV_USER_MAX 16'h0002
`define FMEV_FIELD_MAX 16'h0004
`define FMEV_MARGIN_NORMAL 3'h0
`define FMEV_DF_BLK 7'h10
`define FMEV_PF_BLK_LO 7'h7c
`define FMEV_DF_BYTES 17'h02000
`define FMEV_ERASED 16'hffff

// Bus answers
`define FMEV_RESP_OKAY 2'h0
`define FMEV_RESP_SLVERR 2'h2

`endif

// [hw/fmev_pkg.sv]
/*
 Holds the types of the margin and section erase verify sequencer.
 Assumes nothing of its surroundings.
*/
package fmev_pkg;

    localparam int NBLK = 5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_READ = 3'b010,
        ST_WAIT = 3'b011,
        ST_DONE = 3'b100
    } fmev_state_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } fmev_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } fmev_axi_rsp_t;

    typedef struct packed {
        logic rd_req;
        logic [22:0] rd_addr;
        logic [2:0] rd_margin;
    } fmev_rd_req_t;

    typedef struct packed {
        logic rd_valid;
        logic [15:0] rd_data;
        logic rd_fault;
    } fmev_rd_rsp_t;

endpackage : fmev_pkg

// [tb/fmev_checker.sv]
/*
 Assertions on the ports of fmev_top.
 Assumes the bind at the foot of this file attaches it to every fmev_top.
*/
module fmev_checker #(
    parameter logic [16:0] DF_BYTES = 17'h02000
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Watched ports
    input wire fmev_pkg::fmev_axi_req_t axi_req_i,
    input wire fmev_pkg::fmev_axi_rsp_t axi_rsp_o,
    input wire fmev_pkg::fmev_rd_req_t rd_req_o,
    input wire fmev_pkg::fmev_rd_rsp_t rd_rsp_i,
    input wire logic command_complete_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] rd_a_reg;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);
    // Word offset of the read under way
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_a_reg <= 6'h00;
        end else if (axi_req_i.arvalid && axi_rsp_o.arready) begin
            rd_a_reg <= axi_req_i.araddr[7:2];
        end
    end
    ////////////////////////////////////////
    a_prot_never: assert property (axi_rsp_o.rvalid && rd_a_reg == 6'h00
        |-> !axi_rsp_o.rdata[4]) else $error("protection flag seen set");
    a_unmapped_err: assert property (axi_rsp_o.rvalid && rd_a_reg > 6'h05
        |-> axi_rsp_o.rresp == 2'h2 && axi_rsp_o.rdata == 32'h0) else $error("bad unmapped read");
    a_write_answer: assert property (axi_req_i.awvalid && axi_rsp_o.awready
        && axi_req_i.wvalid && axi_rsp_o.wready |=> ##1 axi_rsp_o.bvalid) else $error("no write answer");
    a_read_answer: assert property (axi_req_i.arvalid && axi_rsp_o.arready
        |=> axi_rsp_o.rvalid && !axi_rsp_o.arready) else $error("no read answer");
    a_bus_hold: assert property (axi_rsp_o.bvalid
        |-> !axi_rsp_o.awready && !axi_rsp_o.wready) else $error("write taken while answering");
    a_read_busy: assert property (rd_req_o.rd_req
        |-> !command_complete_flag_o ##1 !rd_req_o.rd_req) else $error("read request while idle");
    a_read_addr: assert property (rd_req_o.rd_req |-> rd_req_o.rd_addr[22:16] == 7'h10
        && !rd_req_o.rd_addr[0] && {1'b0, rd_req_o.rd_addr[15:0]} < DF_BYTES)
        else $error("read address out of section");
    a_addr_stable: assert property ($changed(rd_req_o.rd_addr)
        |=> rd_req_o.rd_req || command_complete_flag_o) else $error("read address moved");
    a_check_time: assert property ($fell(command_complete_flag_o)
        |=> !command_complete_flag_o ##1 (command_complete_flag_o || rd_req_o.rd_req))
        else $error("bad command timing");
endmodule : fmev_checker

bind fmev_top fmev_checker #(.DF_BYTES(DF_BYTES)) u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .rd_req_o(rd_req_o), .rd_rsp_i(rd_rsp_i),
    .command_complete_flag_o(command_complete_flag_o));

// [tb/fmev_flash_model.sv]
/*
 D-flash read port model: all words erased except one bad address.
 Assumes the same clock and reset as the sequencer.
*/
module fmev_flash_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Read port
    input wire fmev_pkg::fmev_rd_req_t rd_req_i,
    output fmev_pkg::fmev_rd_rsp_t rd_rsp_o,
    // Bench controls
    input wire logic [3:0] lat_i,
    input wire logic [15:0] bad_addr_i,
    input wire logic [1:0] bad_kind_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] cnt;
    logic [15:0] addr;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_rsp_o <= '0;
            busy <= 1'b0;
            cnt <= 4'h0;
            addr <= 16'h0;
        end else begin
            // Outside a valid cycle the data lines keep changing
            rd_rsp_o.rd_valid <= 1'b0;
            rd_rsp_o.rd_data <= ~rd_rsp_o.rd_data;
            rd_rsp_o.rd_fault <= ~rd_rsp_o.rd_fault;
            if (rd_req_i.rd_req) begin
                busy <= 1'b1;
                cnt <= lat_i;
                addr <= rd_req_i.rd_addr[15:0];
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                rd_rsp_o.rd_valid <= 1'b1;
                rd_rsp_o.rd_data <= (addr == bad_addr_i && bad_kind_i == 2'h1) ? 16'h5a5a : 16'hffff;
                rd_rsp_o.rd_fault <= addr == bad_addr_i && bad_kind_i == 2'h2;
            end
        end
    end
endmodule : fmev_flash_model

// [tb/tb_fmev_top.sv]
/*
 Self-checking bench for fmev_top: AXI4-Lite tasks and command runs.
 Assumes package, header, design, flash model and checker compiled first.
*/
module tb_fmev_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [16:0] DFB = 17'h00040;
    logic mclk_i;
    logic arst_n_i;
    fmev_pkg::fmev_axi_req_t req;
    fmev_pkg::fmev_axi_rsp_t rsp;
    fmev_pkg::fmev_rd_req_t rdq;
    fmev_pkg::fmev_rd_rsp_t rds;
    logic cc;
    logic [3:0] lat;
    logic [15:0] bad_a;
    logic [1:0] bad_k;
    logic [15:0] exp_a;
    logic [2:0] exp_dm;
    logic [2:0] exp_m [0:4];
    logic [31:0] d;
    logic [1:0] r;
    logic ok;
    int n_rd;
    int err_total;
    int n_compared;
    int m;
    int c;
    int s;
    int k;
    fmev_top #(.DF_BYTES(DFB)) uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .axi_req_i(req),
        .axi_rsp_o(rsp), .rd_req_o(rdq), .rd_rsp_i(rds), .command_complete_flag_o(cc));
    fmev_flash_model u_flash (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .rd_req_i(rdq),
        .rd_rsp_o(rds), .lat_i(lat), .bad_addr_i(bad_a), .bad_kind_i(bad_k));
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("errors=%0d compared=%0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        int i;
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= v;
        req.wvalid <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge mclk_i);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) break;
        end
        if (i == 60) begin
            err_total++;
            end_of_test();
        end
        r = rsp.bresp;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        int i;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge mclk_i);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) break;
        end
        if (i == 60) begin
            err_total++;
            end_of_test();
        end
        d = rsp.rdata;
        r = rsp.rresp;
    endtask : rd
    // Margin readback of one slot
    task automatic mchk(input int sl);
        wr(32'h10, sl);
        rd(32'h14);
        chk(d, {29'h0, exp_m[sl]});
    endtask : mchk
    // Load words, launch, wait for completion, check status and read count
    task automatic run(input logic [7:0] code, input logic [6:0] blk, input logic [15:0] w1,
        input logic [15:0] w2, input logic [2:0] idx, input logic [31:0] st, input int nrd);
        int i;
        wr(32'h04, 32'h0);
        wr(32'h08, {16'h0, code, 1'b0, blk});
        wr(32'h04, 32'h1);
        wr(32'h08, {16'h0, w1});
        wr(32'h04, 32'h2);
        wr(32'h08, {16'h0, w2});
        wr(32'h04, {29'h0, idx});
        exp_a = w1;
        n_rd = 0;
        wr(32'h00, 32'h80);
        for (i = 0; i < 1000; i++) begin
            @(posedge mclk_i);
            if (cc === 1'b1) break;
        end
        if (i == 1000) begin
            err_total++;
            end_of_test();
        end
        rd(32'h00);
        chk(d, st);
        chk(n_rd, nrd);
        wr(32'h00, 32'h20);
    endtask : run
    // Every read request: address in sequence, D-flash margin applied
    always @(posedge mclk_i) begin
        if (rdq.rd_req === 1'b1) begin
            chk({9'h0, rdq.rd_addr}, {9'h0, 7'h10, exp_a});
            chk({29'h0, rdq.rd_margin}, {29'h0, exp_dm});
            exp_a = exp_a + 16'h2;
            n_rd++;
        end
    end
    ////////////////////////////////////////
    initial begin
        req = '0;
        req.wstrb = 4'hf;
        req.bready = 1'b1;
        req.rready = 1'b1;
        arst_n_i = 1'b0;
        lat = 4'h0;
        bad_a = 16'hffff;
        bad_k = 2'h0;
        exp_a = 16'h0;
        exp_dm = 3'h0;
        n_rd = 0;
        err_total = 0;
        n_compared = 0;
        for (k = 0; k < 5; k++) exp_m[k] = 3'h0;
        repeat (12) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(32'h00);
        chk(d, 32'h80);
        rd(32'h18);
        chk({30'h0, r}, 32'h2);
        wr(32'h20, 32'h1);
        chk({30'h0, r}, 32'h2);
        run(8'h0d, 7'h10, 16'h1, 16'h0, 3'h1, 32'h80, 0);
        exp_m[0] = 3'h1;
        exp_dm = 3'h1;
        run(8'h10, 7'h10, 16'h0, 16'h4, 3'h2, 32'h80, 4);
        lat <= 4'h9;
        run(8'h10, 7'h10, 16'h0, 16'h20, 3'h2, 32'h80, 32);
        lat <= 4'h0;
        run(8'h10, 7'h10, 16'h2, 16'h20, 3'h2, 32'ha0, 0);
        run(8'h10, 7'h10, 16'h1, 16'h1, 3'h2, 32'ha0, 0);
        run(8'h10, 7'h10, 16'h0, 16'h4, 3'h1, 32'ha0, 0);
        run(8'h10, 7'h10, 16'h100, 16'h1, 3'h2, 32'ha0, 0);
        run(8'h10, 7'h10, 16'h0, 16'h0, 3'h2, 32'h80, 0);
        run(8'h10, 7'h10, 16'h10, 16'hfff8, 3'h2, 32'ha0, 0);
        run(8'h11, 7'h10, 16'h0, 16'h0, 3'h2, 32'ha0, 0);
        bad_a <= 16'h4;
        bad_k <= 2'h1;
        run(8'h10, 7'h10, 16'h0, 16'h4, 3'h2, 32'h82, 4);
        bad_a <= 16'h6;
        bad_k <= 2'h2;
        run(8'h10, 7'h10, 16'h0, 16'h4, 3'h2, 32'h83, 4);
        // Field levels only while verifying factory programming
        for (m = 0; m < 2; m++) begin
            wr(32'h0c, m);
            for (c = 0; c < 2; c++) begin
                for (s = 0; s < 6; s++) begin
                    k = s % 4 + 1;
                    ok = s <= (c == 1 ? 4 : 2) && (c == 0 || m == 1);
                    run(c == 1 ? 8'h0e : 8'h0d, 7'h7b + k[6:0], s[15:0], 16'h0, 3'h1,
                        ok ? 32'h80 : 32'ha0, 0);
                    if (ok) exp_m[k] = s[2:0];
                    mchk(k);
                end
            end
        end
        run(8'h10, 7'h10, 16'h0, 16'h2, 3'h2, 32'h80, 2);
        run(8'h0d, 7'h7c, 16'h1, 16'h0, 3'h0, 32'ha0, 0);
        run(8'h0e, 7'h7c, 16'h1, 16'h0, 3'h2, 32'ha0, 0);
        run(8'h0d, 7'h20, 16'h1, 16'h0, 3'h1, 32'ha0, 0);
        for (k = 0; k < 5; k++) mchk(k);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        for (k = 0; k < 5; k++) exp_m[k] = 3'h0;
        exp_dm = 3'h0;
        for (k = 0; k < 5; k++) mchk(k);
        run(8'h10, 7'h10, 16'h0, 16'h1, 3'h2, 32'h80, 1);
        end_of_test();
    end
endmodule : tb_fmev_top
